// File: rtl/ddr_port_cfg.svh
// constants of the ddr sram data port and its write queue
// assumes inclusion by bare name from the port rtl file and the controller model
// Summary of operation
// - Write data is captured on rising edges of both input clocks, two words per input cycle.
// - Read data is launched on rising edges of both output clocks.
// - In single clock mode read data is launched on the input clock edges instead.
// - With no read selected the data pins float without any output enable input.
// - Load low on a positive input edge while idle defines a new bus cycle with its address and direction.
// - Every transaction moves exactly two words as one burst.
// - On the 8-bit port the nibble masks are sampled with the data they qualify.
// - The first nibble mask covers bits 3..0 and the second bits 7..4.
// - A deasserted nibble mask leaves that stored nibble unchanged.
// - On 9, 18 and 36-bit ports the lane masks are sampled with the data they qualify.
// - Each lane mask covers one 9-bit lane, mask 0 on the lowest bits.
// - A deasserted lane mask keeps the stored lane and drops the incoming one.
// - Direction high at load requests a read, low a write.
// - Every access starts on a rising positive input edge, where controls are taken.
`ifndef DDR_PORT_CFG_SVH
`define DDR_PORT_CFG_SVH

// ************************************************************
// geometry
// ************************************************************
`define ADDR_W 4
`define BURST_LEN 2
`define NIBBLE_W 4
`define LANE_W 9
`define NIBBLE_PORT_W 8
`define FIFO_DEPTH 8

// ************************************************************
// encodings
// ************************************************************
`define DIR_READ 1'b1
`define WORD_FIRST 1'b0
`define WORD_SECOND 1'b1
`define CNT_W 2

`endif

// File: rtl/ddr_port_pkg.sv
// types shared by the ddr sram data port
// assumes nothing beyond a systemverilog compiler
package ddr_port_pkg;

   // ************************************************************
   // bus cycle sequencer
   // ************************************************************
   typedef enum logic [4:0]
   {
      st_idle = 5'h01,
      st_wr_first = 5'h02,
      st_wr_second = 5'h04,
      st_rd_first = 5'h08,
      st_rd_second = 5'h10
   } port_state_t;

endpackage

// File: rtl/ddr_sram_data_port.sv
// data side of a two-word burst ddr sram: capture, masked store, read launch
// assumes all pins asynchronous to core_clk; link clocks much slower than core_clk
`timescale 1ns/1ns
`default_nettype none
`include "ddr_port_cfg.svh"
module ddr_sram_data_port
   import ddr_port_pkg::*;
#(
   parameter int DATA_W = 18,
   localparam int LANE = (DATA_W == `NIBBLE_PORT_W) ? `NIBBLE_W : `LANE_W,
   localparam int MASK_W = DATA_W / LANE
)
(
   input wire logic core_clk,
   input wire logic rst,
   input wire logic input_edge_pos,
   input wire logic input_edge_neg,
   input wire logic rd_out_edge_pos,
   input wire logic rd_out_edge_neg,
   input wire logic single_clock_mode,
   input wire logic load_n,
   input wire logic direction_sel,
   input wire logic [`ADDR_W-1:0] addr,
   input wire logic [DATA_W-1:0] data_in,
   input wire logic [MASK_W-1:0] nibble_write_mask_n,
   input wire logic [MASK_W-1:0] lane_write_mask_n,
   output logic [DATA_W-1:0] read_data,
   output logic read_oe,
   output logic write_dropped
);
   localparam int PIN_W = 7 + `ADDR_W + DATA_W + MASK_W;
   localparam int ENTRY_W = `ADDR_W + 1 + MASK_W + DATA_W;
   localparam int WORDS = 2 ** (`ADDR_W + 1);

   // ************************************************************
   // pin synchroniser
   // ************************************************************
   logic [PIN_W-1:0] pin_meta;
   logic [PIN_W-1:0] pin_sync;
   logic [MASK_W-1:0] mask_pin;
   logic s_kp;
   logic s_kn;
   logic s_cp;
   logic s_cn;
   logic s_single;
   logic s_load;
   logic s_dir;
   logic [`ADDR_W-1:0] s_addr;
   logic [DATA_W-1:0] s_data;
   logic [MASK_W-1:0] s_mask;

   // width 8 takes nibble masks, the wider ports take lane masks
   generate
      if (DATA_W == `NIBBLE_PORT_W)
      begin : g_nibble
         assign mask_pin = nibble_write_mask_n;
      end
      else
      begin : g_lane_pins
         assign mask_pin = lane_write_mask_n;
      end
   endgenerate

   // load is inverted before syncing so a cleared stage never reads as a load
   always_ff @(posedge core_clk)
   begin
      if (rst)
      begin
         pin_meta <= '0;
         pin_sync <= '0;
      end
      else
      begin
         pin_meta <= {input_edge_pos, input_edge_neg, rd_out_edge_pos, rd_out_edge_neg,
                      single_clock_mode, ~load_n, direction_sel, addr, data_in, mask_pin};
         pin_sync <= pin_meta;
      end
   end

   assign {s_kp, s_kn, s_cp, s_cn, s_single, s_load, s_dir, s_addr, s_data, s_mask} = pin_sync;

   // ************************************************************
   // link clock edges
   // ************************************************************
   logic [3:0] clk_prev;
   logic kp_rise;
   logic kn_rise;
   logic cp_rise;
   logic cn_rise;
   logic launch_pos;
   logic launch_neg;

   always_ff @(posedge core_clk)
   begin
      if (rst)
         clk_prev <= '0;
      else
         clk_prev <= {s_kp, s_kn, s_cp, s_cn};
   end

   // data and clock pass the same two stages, so their skew is kept
   assign kp_rise = s_kp && !clk_prev[3];
   assign kn_rise = s_kn && !clk_prev[2];
   assign cp_rise = s_cp && !clk_prev[1];
   assign cn_rise = s_cn && !clk_prev[0];
   assign launch_pos = s_single ? kp_rise : cp_rise;
   assign launch_neg = s_single ? kn_rise : cn_rise;

   // ************************************************************
   // bus cycle sequencer
   // ************************************************************
   port_state_t state;
   logic [`ADDR_W-1:0] txn_addr;
   logic load_take;
   logic fetch_first;
   logic fetch_second;

   // loads are only taken while idle; a load mid burst is ignored
   assign load_take = (state == st_idle) && kp_rise && s_load;
   assign fetch_first = (state == st_rd_first) && launch_pos;
   assign fetch_second = (state == st_rd_second) && launch_neg;

   always_ff @(posedge core_clk)
   begin
      if (rst)
         state <= st_idle;
      else
      begin
         case (state)
            st_idle:
               if (load_take)
                  state <= (s_dir == `DIR_READ) ? st_rd_first : st_wr_first;
            st_wr_first:
               if (kp_rise)
                  state <= st_wr_second;
            st_wr_second:
               if (kn_rise)
                  state <= st_idle;
            st_rd_first:
               if (launch_pos)
                  state <= st_rd_second;
            st_rd_second:
               if (launch_neg)
                  state <= st_idle;
            default:
               state <= st_idle;
         endcase
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         txn_addr <= '0;
      else if (load_take)
         txn_addr <= s_addr;
   end

   // ************************************************************
   // write capture into the queue
   // ************************************************************
   wr_queue_if #(.ENTRY_W(ENTRY_W)) wq ();
   logic push_word;
   logic [DATA_W-1:0] pop_data;
   logic [MASK_W-1:0] pop_mask;
   logic [`ADDR_W:0] pop_idx;
   logic pop_fire;

   assign wq.push_valid = ((state == st_wr_first) && kp_rise) ||
                          ((state == st_wr_second) && kn_rise);
   assign push_word = (state == st_wr_second) ? `WORD_SECOND : `WORD_FIRST;
   // mask rides with its own data word, same edge
   assign wq.push_entry = {txn_addr, push_word, s_mask, s_data};

   // array has one port; a read fetch holds off the drain for that cycle
   assign wq.pop_ready = !(fetch_first || fetch_second);
   assign {pop_idx, pop_mask, pop_data} = wq.pop_entry;
   assign pop_fire = wq.pop_valid && wq.pop_ready;

   wr_queue #(.WIDTH(ENTRY_W), .DEPTH(`FIFO_DEPTH)) u_wr_queue
   (
      .core_clk(core_clk),
      .rst(rst),
      .q(wq.queue)
   );

   // the controller cannot be stalled, so an overflow is flagged instead
   always_ff @(posedge core_clk)
   begin
      if (rst)
         write_dropped <= 1'b0;
      else if (wq.push_valid && !wq.push_ready)
         write_dropped <= 1'b1;
   end

   // ************************************************************
   // masked store
   // ************************************************************
   logic [DATA_W-1:0] mem [0:WORDS-1];
   logic [DATA_W-1:0] old_word;
   logic [DATA_W-1:0] merged;
   logic [LANE-1:0] lane0_new;
   logic [LANE-1:0] lane0_old;

   assign old_word = mem[pop_idx];
   assign lane0_new = pop_data[LANE-1:0];
   assign lane0_old = old_word[LANE-1:0];

   // mask i covers bits i*LANE up; high mask keeps the stored part
   generate
      for (genvar i = 0; i < MASK_W; i++)
      begin : g_lane
         assign merged[i*LANE +: LANE] = pop_mask[i] ? old_word[i*LANE +: LANE]
                                                     : pop_data[i*LANE +: LANE];
      end
   endgenerate

   always_ff @(posedge core_clk)
   begin
      if (pop_fire)
         mem[pop_idx] <= merged;
   end

   // ************************************************************
   // read launch
   // ************************************************************
   always_ff @(posedge core_clk)
   begin
      if (rst)
         read_data <= '0;
      else if (fetch_first)
         read_data <= mem[{txn_addr, `WORD_FIRST}];
      else if (fetch_second)
         read_data <= mem[{txn_addr, `WORD_SECOND}];
   end

   // pins float from the next launch edge after the burst; back to back
   // reads therefore show one launch period of float between bursts
   always_ff @(posedge core_clk)
   begin
      if (rst)
         read_oe <= 1'b0;
      else if (fetch_first)
         read_oe <= 1'b1;
      else if (launch_pos)
         read_oe <= 1'b0;
   end

   // ************************************************************
   // checks
   // ************************************************************
   logic [`CNT_W-1:0] burst_count;
   logic [LANE-1:0] top_new;
   logic [LANE-1:0] top_old;

   // top lane is the one the highest mask bit covers
   assign top_new = pop_data[DATA_W-1 -: LANE];
   assign top_old = old_word[DATA_W-1 -: LANE];

   always_ff @(posedge core_clk)
   begin
      if (rst || load_take)
         burst_count <= '0;
      else if (wq.push_valid || fetch_first || fetch_second)
         burst_count <= burst_count + 1'b1;
   end

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (rst);

   sequence seq_wr_load;
      load_take && (s_dir != `DIR_READ);
   endsequence

   sequence seq_rd_load;
      load_take && (s_dir == `DIR_READ);
   endsequence

   sequence seq_burst_end;
      (state != st_idle) ##1 (state == st_idle);
   endsequence

   sequence seq_second_fetch;
      fetch_second;
   endsequence

   sequence seq_wr_hold_first;
      (state == st_wr_first) && !kp_rise;
   endsequence

   sequence seq_wr_hold_second;
      (state == st_wr_second) && !kn_rise;
   endsequence

   a_load_starts_write: assert property (seq_wr_load |=> state == st_wr_first)
      else $error("write load did not start a write burst");
   a_load_starts_read: assert property (seq_rd_load |=> state == st_rd_first)
      else $error("read load did not start a read burst");
   a_first_word_push: assert property ((state == st_wr_first) && kp_rise |->
      wq.push_valid && (push_word == `WORD_FIRST) && (wq.push_entry[DATA_W-1:0] == s_data))
      else $error("first write word not captured on positive edge");
   a_second_mask_push: assert property ((state == st_wr_second) && kn_rise |->
      wq.push_valid && (push_word == `WORD_SECOND) &&
      (wq.push_entry[DATA_W +: MASK_W] == s_mask))
      else $error("second word mask not taken with its data");
   a_burst_of_two: assert property (seq_burst_end |-> burst_count == `CNT_W'(`BURST_LEN))
      else $error("burst did not move exactly two words");
   a_launch_drives: assert property (fetch_first |=> read_oe ##0
      (read_data == mem[{txn_addr, `WORD_FIRST}]))
      else $error("first read word not driven at launch");
   a_single_uses_k: assert property (s_single && (state == st_rd_first) && !kp_rise |=>
      state == st_rd_first)
      else $error("single clock mode launched without input edge");
   a_float_no_read: assert property (read_oe && launch_pos && (state != st_rd_first) |=>
      !read_oe [*2])
      else $error("pins still driven with no read selected");
   a_masked_lane_kept: assert property (pop_fire && pop_mask[0] |=>
      mem[$past(pop_idx)][LANE-1:0] == $past(lane0_old))
      else $error("masked lane was overwritten");
   a_open_lane_written: assert property (pop_fire && !pop_mask[0] |=>
      mem[$past(pop_idx)][LANE-1:0] == $past(lane0_new))
      else $error("enabled lane not written");
   a_top_lane_kept: assert property (pop_fire && pop_mask[MASK_W-1] |=>
      mem[$past(pop_idx)][DATA_W-1 -: LANE] == $past(top_old))
      else $error("masked top lane was overwritten");
   a_top_lane_written: assert property (pop_fire && !pop_mask[MASK_W-1] |=>
      mem[$past(pop_idx)][DATA_W-1 -: LANE] == $past(top_new))
      else $error("enabled top lane not written");
   a_second_launch: assert property (seq_second_fetch |=> read_oe ##0
      (read_data == mem[{txn_addr, `WORD_SECOND}]))
      else $error("second read word not driven at launch");
   a_dual_uses_c: assert property (!s_single && (state == st_rd_first) && !cp_rise |=>
      state == st_rd_first)
      else $error("dual clock mode launched without output edge");
   a_single_second_k: assert property (s_single && (state == st_rd_second) && !kn_rise |=>
      state == st_rd_second)
      else $error("single clock mode second word without input edge");
   a_wr_first_waits: assert property (seq_wr_hold_first |=> state == st_wr_first)
      else $error("first write word taken without positive edge");
   a_wr_second_waits: assert property (seq_wr_hold_second |=> state == st_wr_second)
      else $error("second write word taken without negative edge");
   a_idle_floats: assert property ((state == st_idle) && !read_oe |=> !read_oe)
      else $error("pins driven while no read is selected");
   a_addr_held: assert property ((state != st_idle) |=> $stable(txn_addr))
      else $error("burst address changed inside a burst");
   a_push_accepted: assert property (wq.push_valid |-> wq.push_ready)
      else $error("write word found the queue full");
endmodule
`default_nettype wire

// File: rtl/wr_queue.sv
// write queue: captured words wait here until the array port is free
// assumes synchronous active high reset on core_clk
`timescale 1ns/1ns
`default_nettype none
module wr_queue
#(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)
(
   input wire logic core_clk,
   input wire logic rst,
   wr_queue_if.queue q
);
   localparam int PTR_W = $clog2(DEPTH);

   logic [WIDTH-1:0] slot [0:DEPTH-1];
   logic [PTR_W:0] wr_ptr;
   logic [PTR_W:0] rd_ptr;
   logic full;
   logic empty;

   // extra pointer bit tells full from empty
   assign empty = (wr_ptr == rd_ptr);
   assign full = (wr_ptr[PTR_W] != rd_ptr[PTR_W]) &&
                 (wr_ptr[PTR_W-1:0] == rd_ptr[PTR_W-1:0]);
   assign q.push_ready = !full;
   assign q.pop_valid = !empty;
   assign q.pop_entry = slot[rd_ptr[PTR_W-1:0]];

   always_ff @(posedge core_clk)
   begin
      if (rst)
         wr_ptr <= '0;
      else if (q.push_valid && !full)
      begin
         slot[wr_ptr[PTR_W-1:0]] <= q.push_entry;
         wr_ptr <= wr_ptr + 1'b1;
      end
   end

   always_ff @(posedge core_clk)
   begin
      if (rst)
         rd_ptr <= '0;
      else if (q.pop_ready && !empty)
         rd_ptr <= rd_ptr + 1'b1;
   end
endmodule
`default_nettype wire

// File: rtl/wr_queue_if.sv
// handshake bundle between the data port and its write queue
// assumes both ends run on core_clk
`timescale 1ns/1ns
`default_nettype none
interface wr_queue_if #(parameter int ENTRY_W = 8);
   logic push_valid;
   logic push_ready;
   logic [ENTRY_W-1:0] push_entry;
   logic pop_valid;
   logic pop_ready;
   logic [ENTRY_W-1:0] pop_entry;

   modport user
   (
      output push_valid, push_entry, pop_ready,
      input push_ready, pop_valid, pop_entry
   );
   modport queue
   (
      input push_valid, push_entry, pop_ready,
      output push_ready, pop_valid, pop_entry
   );
endinterface
`default_nettype wire

// File: verif/ddr_ctrl_model.sv
// memory controller model: link clocks, load, direction, address, write data, lane masks
// assumes core_clk from the bench; samples the resolved data pins in mid phase
`timescale 1ns/1ns
`default_nettype none
`include "ddr_port_cfg.svh"
module ddr_ctrl_model
#(
   parameter int DATA_W = 18,
   parameter int MASK_W = 2
)
(
   input wire logic core_clk,
   input wire logic [DATA_W-1:0] dq,
   output logic input_edge_pos,
   output logic input_edge_neg,
   output logic rd_out_edge_pos,
   output logic rd_out_edge_neg,
   output logic single_clock_mode,
   output logic load_n,
   output logic direction_sel,
   output logic [`ADDR_W-1:0] addr,
   output logic [DATA_W-1:0] data_in,
   output logic [MASK_W-1:0] lane_write_mask_n
);
   logic [DATA_W-1:0] qd [0:5];

   initial
   begin
      input_edge_pos = 1'b0;
      input_edge_neg = 1'b0;
      rd_out_edge_pos = 1'b0;
      rd_out_edge_neg = 1'b0;
      single_clock_mode = 1'b1;
      load_n = 1'b1;
      direction_sel = 1'b0;
      addr = 4'h0;
      data_in = '0;
      lane_write_mask_n = '1;
   end

   // released lines show the inverse of their last value, never a held copy
   task automatic scramble();
      data_in = ~data_in;
      lane_write_mask_n = ~lane_write_mask_n;
      addr = ~addr;
      direction_sel = ~direction_sel;
   endtask

   // ************************************************************
   // one bus cycle: six link half periods, clocks still outside
   // ************************************************************
   // output clocks lag the input clocks by half a period in dual clock mode
   task automatic frame(input logic rd, input logic sm, input logic [`ADDR_W-1:0] a,
      input logic [DATA_W-1:0] w0, input logic [DATA_W-1:0] w1,
      input logic [MASK_W-1:0] m0, input logic [MASK_W-1:0] m1);
      int i;
      @(negedge core_clk);
      single_clock_mode = sm;
      scramble();
      load_n = 1'b0;
      direction_sel = rd;
      addr = a;
      repeat (2) @(negedge core_clk);
      for (i = 0; i < 6; i++)
      begin
         input_edge_pos = ~i[0];
         input_edge_neg = i[0];
         rd_out_edge_pos = sm ? 1'b0 : i[0];
         rd_out_edge_neg = sm ? 1'b0 : ~i[0];
         repeat (2) @(negedge core_clk);
         qd[i] = dq;
         scramble();
         load_n = 1'b1;
         if (!rd && i == 1)
         begin
            data_in = w0;
            lane_write_mask_n = m0;
         end
         if (!rd && i == 2)
         begin
            data_in = w1;
            lane_write_mask_n = m1;
         end
         repeat (2) @(negedge core_clk);
      end
      input_edge_neg = 1'b0;
      rd_out_edge_pos = 1'b0;
      rd_out_edge_neg = 1'b0;
      repeat (8) @(negedge core_clk);
   endtask
endmodule
`default_nettype wire

// File: verif/test_ddr_sram_data_port.sv
// bench of the ddr sram data port and its write queue
// assumes the controller model in verif and the rtl include path
`timescale 1ns/1ns
`default_nettype none
module test_ddr_sram_data_port;
   localparam int DW = 18;
   localparam int MW = 2;
   logic core_clk;
   logic rst;
   int n_mismatch;
   int checked;
   wire k_pos, k_neg, c_pos, c_neg, sm, ld_n, dir;
   wire [3:0] adr;
   wire [DW-1:0] din;
   wire [MW-1:0] lmask_n;
   wire [DW-1:0] read_data;
   wire read_oe;
   wire write_dropped;
   // pins float when the port is not driving
   wire [DW-1:0] dq = read_oe ? read_data : 'z;

   // 8-bit port for the nibble masks; its lane mask input is unused there
   wire k8_pos, k8_neg, c8_pos, c8_neg, sm8, ld8_n, dir8;
   wire [3:0] adr8;
   wire [7:0] din8;
   wire [MW-1:0] nmask_n;
   wire [7:0] read_data8;
   wire read_oe8;
   wire write_dropped8;
   wire [7:0] dq8 = read_oe8 ? read_data8 : 'z;
   ddr_ctrl_model #(.DATA_W(8), .MASK_W(MW)) ctrl8 (.core_clk(core_clk), .dq(dq8),
      .input_edge_pos(k8_pos), .input_edge_neg(k8_neg), .rd_out_edge_pos(c8_pos),
      .rd_out_edge_neg(c8_neg), .single_clock_mode(sm8), .load_n(ld8_n),
      .direction_sel(dir8), .addr(adr8), .data_in(din8), .lane_write_mask_n(nmask_n));
   ddr_sram_data_port #(.DATA_W(8)) uut_nibble (.core_clk(core_clk), .rst(rst),
      .input_edge_pos(k8_pos), .input_edge_neg(k8_neg), .rd_out_edge_pos(c8_pos),
      .rd_out_edge_neg(c8_neg), .single_clock_mode(sm8), .load_n(ld8_n),
      .direction_sel(dir8), .addr(adr8), .data_in(din8), .nibble_write_mask_n(nmask_n),
      .lane_write_mask_n(2'h3), .read_data(read_data8), .read_oe(read_oe8),
      .write_dropped(write_dropped8));
   ddr_ctrl_model #(.DATA_W(DW), .MASK_W(MW)) ctrl (.core_clk(core_clk), .dq(dq),
      .input_edge_pos(k_pos), .input_edge_neg(k_neg), .rd_out_edge_pos(c_pos),
      .rd_out_edge_neg(c_neg), .single_clock_mode(sm), .load_n(ld_n),
      .direction_sel(dir), .addr(adr), .data_in(din), .lane_write_mask_n(lmask_n));
   ddr_sram_data_port #(.DATA_W(DW)) uut (.core_clk(core_clk), .rst(rst),
      .input_edge_pos(k_pos), .input_edge_neg(k_neg), .rd_out_edge_pos(c_pos),
      .rd_out_edge_neg(c_neg), .single_clock_mode(sm), .load_n(ld_n),
      .direction_sel(dir), .addr(adr), .data_in(din), .nibble_write_mask_n(2'h3),
      .lane_write_mask_n(lmask_n), .read_data(read_data), .read_oe(read_oe),
      .write_dropped(write_dropped));

   // ************************************************************
   // compare and closing
   // ************************************************************
   task automatic chk_data(input logic [DW-1:0] got, input logic [DW-1:0] exp,
      input string what);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic chk_bit(input logic got, input logic exp, input string what);
      checked++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: %s got %b expected %b", $time, what, got, exp);
      end
   endtask

   task automatic test_done();
      $display("comparisons %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask

   // ************************************************************
   // bus cycle helpers
   // ************************************************************
   task automatic wr(input logic [3:0] a, input logic [DW-1:0] w0, input logic [DW-1:0] w1,
      input logic [MW-1:0] m0, input logic [MW-1:0] m1);
      int i;
      ctrl.frame(1'b0, 1'b1, a, w0, w1, m0, m1);
      for (i = 0; i < 6; i++)
         chk_data(ctrl.qd[i], 'z, "pins during write");
   endtask

   // single mode shows word0 one half period later than dual clock mode
   task automatic rd(input logic [3:0] a, input logic [DW-1:0] e0, input logic [DW-1:0] e1,
      input logic s);
      int b;
      b = s ? 3 : 2;
      ctrl.frame(1'b1, s, a, '0, '0, 2'h0, 2'h0);
      chk_data(ctrl.qd[0], 'z, "pins before launch");
      chk_data(ctrl.qd[b], e0, "first read word");
      chk_data(ctrl.qd[b+1], e1, "second read word");
      chk_data(ctrl.qd[b+2], 'z, "pins after burst");
   endtask

   // ************************************************************
   // scenarios
   // ************************************************************
   task automatic t_reset();
      chk_bit(read_oe, 1'b0, "drive after reset");
      chk_bit(write_dropped, 1'b0, "drop flag after reset");
   endtask

   // bursts back to back run through the write queue; no word may be lost
   task automatic t_queue_path();
      wr(4'h5, 18'h12345, 18'h2ABCD, 2'h0, 2'h0);
      wr(4'h6, 18'h00001, 18'h3FFFE, 2'h0, 2'h0);
      rd(4'h5, 18'h12345, 18'h2ABCD, 1'b1);
      rd(4'h6, 18'h00001, 18'h3FFFE, 1'b1);
      chk_bit(write_dropped, 1'b0, "queue kept every word");
   endtask

   // 8-bit port: mask0 keeps bits 3..0 of word0, mask1 bits 7..4 of word1
   task automatic t_nibble_mask();
      ctrl8.frame(1'b0, 1'b1, 4'h3, 8'h5A, 8'hC3, 2'h0, 2'h0);
      ctrl8.frame(1'b0, 1'b1, 4'h3, 8'hF0, 8'h0F, 2'h1, 2'h2);
      ctrl8.frame(1'b1, 1'b1, 4'h3, '0, '0, 2'h0, 2'h0);
      chk_data({10'h000, ctrl8.qd[3]}, {10'h000, 8'hFA}, "nibble word0");
      chk_data({10'h000, ctrl8.qd[4]}, {10'h000, 8'hCF}, "nibble word1");
      chk_bit(write_dropped8, 1'b0, "no nibble write dropped");
   endtask

   task automatic t_single_clock();
      wr(4'h0, 18'h2A5C3, 18'h15A3C, 2'h0, 2'h0);
      rd(4'h0, 18'h2A5C3, 18'h15A3C, 1'b1);
   endtask

   task automatic t_output_clock();
      wr(4'hF, 18'h3F00F, 18'h00FF0, 2'h0, 2'h0);
      rd(4'hF, 18'h3F00F, 18'h00FF0, 1'b0);
      rd(4'h0, 18'h2A5C3, 18'h15A3C, 1'b0);
   endtask

   // word0 keeps its low lane, word1 its high lane
   task automatic t_lane_mask();
      wr(4'h0, 18'h0F0F0, 18'h3C3C3, 2'h1, 2'h2);
      rd(4'h0, {9'h078, 9'h1C3}, {9'h0AD, 9'h1C3}, 1'b0);
      chk_bit(write_dropped, 1'b0, "no write dropped");
   endtask

   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      core_clk = 1'b0;
      forever #25 core_clk = ~core_clk;
   end

   initial
   begin
      #3000000;
      n_mismatch++;
      $display("CHECK FAILED at %0t: run did not finish", $time);
      test_done();
   end

   initial
   begin
      n_mismatch = 0;
      checked = 0;
      rst = 1'b1;
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
      repeat (4) @(negedge core_clk);
      t_reset();
      t_single_clock();
      t_output_clock();
      t_lane_mask();
      t_queue_path();
      t_nibble_mask();
      test_done();
   end
endmodule
`default_nettype wire
